//--- adc_config_register_bank.sv
// Our own choice: the address-and-strobe port.
`include "cfg_bank_regs.svh"

module adc_config_register_bank
  import cfg_bank_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  // Pins and analog status
  input  wire logic                    clock_source_select_pin_i,
  input  wire logic                    bias_open_i,
  input  wire logic                    osc_clk_i,
  input  wire logic [NUM_CH*3-1:0]     channel_input_select_i,
  // Clock pin, output side
  output logic                         clk_pin_o,
  output logic                         clk_pin_oe_o,
  // Analog controls
  output cfg_bank_pkg::ctrl_s          ctrl_o,
  output logic      [12:0]             modulator_divider_o,
  output logic                         test_level_o,
  output logic      [NUM_CH-1:0]       bias_route_o,
  // Interrupt
  output logic                         irq_o
);

  import cfg_bank_pkg::*;

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  rate_and_clock_config;
    logic [7:0]  test_signal_config;
    logic [7:0]  reference_and_bias_config;
    logic [7:0]  irq_status;
    logic [7:0]  irq_enable;
    logic [7:0]  rdata;
    logic [12:0] divider;
    logic        sel_meta;
    logic        sel_sync;
    logic        open_meta;
    logic        open_sync;
    logic        open_prev;
  } bank_s;

  bank_s    st_ff;
  bank_s    nxt_st;
  bus_req_s req;
  logic     test_level;

  // Divider for a rate code: 64 shifted left by the code
  function automatic logic [12:0] rate_divider(input logic [2:0] code);
    rate_divider = 13'h1 << (`DIV_BASE_LOG2 + {1'b0, code});
  endfunction : rate_divider

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Pins are asynchronous to the bank; two flops before use
    nxt_st.sel_meta  = clock_source_select_pin_i;
    nxt_st.sel_sync  = st_ff.sel_meta;
    nxt_st.open_meta = bias_open_i;
    nxt_st.open_sync = st_ff.open_meta;
    nxt_st.open_prev = st_ff.open_sync;

    // Live lead-off flag, never written by software
    nxt_st.reference_and_bias_config[`BIT_BIAS_STAT] =
      st_ff.reference_and_bias_config[`BIT_BIAS_SENSE] &
      st_ff.open_sync;

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        `ADR_RATE_CLK: begin
          nxt_st.rate_and_clock_config = req.wdata;
        end
        `ADR_TEST_SIG: begin
          nxt_st.test_signal_config = req.wdata;
        end
        `ADR_REF_BIAS: begin
          // Flag bit masked out so a write cannot fake a lead-off
          nxt_st.reference_and_bias_config =
            (req.wdata & `MSK_REF_BIAS_WR) |
            (nxt_st.reference_and_bias_config &
             ~`MSK_REF_BIAS_WR);
        end
        `ADR_IRQ_CLEAR: begin
          nxt_st.irq_status = st_ff.irq_status & ~req.wdata;
        end
        `ADR_IRQ_ENABLE: begin
          nxt_st.irq_enable = req.wdata;
        end
        default: begin
        end
      endcase
    end

    // Events set after the clear so a same-cycle event wins
    if (st_ff.open_sync & ~st_ff.open_prev)
      nxt_st.irq_status[`IRQ_LEADOFF] = 1'b1;
    if (~st_ff.open_sync & st_ff.open_prev)
      nxt_st.irq_status[`IRQ_RECONNECT] = 1'b1;
    // Reserved rate code or forbidden test frequency
    if (req.wr && req.addr == `ADR_RATE_CLK &&
        req.wdata[2:0] == `DIV_RESERVED)
      nxt_st.irq_status[`IRQ_BAD_CODE] = 1'b1;
    if (req.wr && req.addr == `ADR_TEST_SIG &&
        req.wdata[1:0] == `FREQ_ILLEGAL)
      nxt_st.irq_status[`IRQ_BAD_CODE] = 1'b1;

    // Reserved rate code keeps the last legal divider
    if (st_ff.rate_and_clock_config[2:0] != `DIV_RESERVED)
      nxt_st.divider =
        rate_divider(st_ff.rate_and_clock_config[2:0]);

    // Read data valid the cycle after the strobe only
    nxt_st.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `ADR_RATE_CLK:   nxt_st.rdata = st_ff.rate_and_clock_config;
        `ADR_TEST_SIG:   nxt_st.rdata = st_ff.test_signal_config;
        `ADR_REF_BIAS:   nxt_st.rdata = st_ff.reference_and_bias_config;
        `ADR_IRQ_STATUS: nxt_st.rdata = st_ff.irq_status;
        `ADR_IRQ_ENABLE: nxt_st.rdata = st_ff.irq_enable;
        default:         nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff                           <= '0;
      st_ff.rate_and_clock_config     <= `RST_RATE_CLK;
      st_ff.test_signal_config        <= `RST_TEST_SIG;
      st_ff.reference_and_bias_config <= `RST_REF_BIAS;
      st_ff.irq_status                <= `RST_IRQ;
      st_ff.irq_enable                <= `RST_IRQ;
      st_ff.divider                   <= `RST_DIVIDER;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------
  // Calibration signal generator
  // -------------------------------------------------------------
  test_pulse_gen #(
    .CNT_W (22)
  ) u_test_pulse_gen (
    .sys_clk_i               (sys_clk_i),
    .rst_n_i                 (rst_n_i),
    .test_frequency_select_i (st_ff.test_signal_config[1:0]),
    .test_level_o            (test_level)
  );

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign rdata_o             = st_ff.rdata;
  assign modulator_divider_o = st_ff.divider;
  // Test level only meaningful when generated internally
  assign test_level_o = test_level &
    st_ff.test_signal_config[`BIT_TEST_INT];

  // Oscillator onto the clock pin; pin is an output only when enabled
  assign clk_pin_oe_o = st_ff.sel_sync &
    st_ff.rate_and_clock_config[`BIT_OSC_OUT_EN];
  assign clk_pin_o = clk_pin_oe_o & osc_clk_i;

  always_comb begin
    ctrl_o.chain_readback =
      st_ff.rate_and_clock_config[`BIT_CHAIN_MODE];
    ctrl_o.osc_out_en = st_ff.rate_and_clock_config[`BIT_OSC_OUT_EN];
    ctrl_o.test_internal = st_ff.test_signal_config[`BIT_TEST_INT];
    ctrl_o.test_amp_double =
      st_ff.test_signal_config[`BIT_TEST_AMP];
    ctrl_o.test_frequency_select = st_ff.test_signal_config[1:0];
    ctrl_o.ref_buffer_enable =
      st_ff.reference_and_bias_config[`BIT_REF_BUF];
    ctrl_o.bias_measure_route =
      st_ff.reference_and_bias_config[`BIT_BIAS_MEASURE_ROUTE];
    ctrl_o.bias_reference_internal =
      st_ff.reference_and_bias_config[`BIT_BIAS_REF];
    ctrl_o.bias_buffer_enable =
      st_ff.reference_and_bias_config[`BIT_BIAS_BUF];
    ctrl_o.bias_sense_enable =
      st_ff.reference_and_bias_config[`BIT_BIAS_SENSE];
  end

  // Per-channel bias input routing switches
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      bias_route_o[i] =
        st_ff.reference_and_bias_config[`BIT_BIAS_MEASURE_ROUTE] &
        (channel_input_select_i[i*3 +: 3] == `CODE_BIAS_IN);
    end
  end

  // Level interrupt while an enabled event is pending
  assign irq_o = |(st_ff.irq_status & st_ff.irq_enable);

endmodule : adc_config_register_bank

//--- cfg_bank_regs.svh
`ifndef CFG_BANK_REGS_SVH
`define CFG_BANK_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADR_RATE_CLK    8'h01
`define ADR_TEST_SIG    8'h02
`define ADR_REF_BIAS    8'h03
`define ADR_IRQ_STATUS  8'h04
`define ADR_IRQ_CLEAR   8'h05
`define ADR_IRQ_ENABLE  8'h06

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_RATE_CLK    8'h96
`define RST_TEST_SIG    8'hc0
`define RST_REF_BIAS    8'h60
`define RST_IRQ         8'h00
`define RST_DIVIDER     13'h1000

// ---------------------------------------------------------------
// Field positions and codes
// ---------------------------------------------------------------
`define BIT_CHAIN_MODE  6
`define BIT_OSC_OUT_EN  5
`define BIT_TEST_INT    4
`define BIT_TEST_AMP    2
`define BIT_REF_BUF     7
`define BIT_BIAS_MEASURE_ROUTE   4
`define BIT_BIAS_REF    3
`define BIT_BIAS_BUF    2
`define BIT_BIAS_SENSE  1
`define BIT_BIAS_STAT   0
`define MSK_REF_BIAS_WR 8'hfe
`define CODE_BIAS_IN    3'h2
`define DIV_BASE_LOG2   4'h6
`define DIV_RESERVED    3'h7
`define FREQ_SLOW_LOG2  5'h15
`define FREQ_FAST_LOG2  5'h14
`define FREQ_DC         2'h3
`define FREQ_ILLEGAL    2'h2
`define FREQ_SLOW       2'h0
`define FREQ_FAST       2'h1

// Interrupt status bits
`define IRQ_LEADOFF     0
`define IRQ_RECONNECT   1
`define IRQ_BAD_CODE    2

`endif

//--- cfg_bank_pkg.sv
package cfg_bank_pkg;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // Decoded analog controls
  typedef struct packed {
    logic       chain_readback;
    logic       osc_out_en;
    logic       test_internal;
    logic       test_amp_double;
    logic [1:0] test_frequency_select;
    logic       ref_buffer_enable;
    logic       bias_measure_route;
    logic       bias_reference_internal;
    logic       bias_buffer_enable;
    logic       bias_sense_enable;
  } ctrl_s;

endpackage : cfg_bank_pkg

//--- test_pulse_gen.sv
`include "cfg_bank_regs.svh"

// Calibration signal from a free-running master clock count
module test_pulse_gen #(
  parameter int CNT_W = 22
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic [1:0] test_frequency_select_i,
  // Output
  output logic            test_level_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
  } gen_s;

  gen_s st_ff;
  gen_s nxt_st;

  // -------------------------------------------------------------
  // Divider: period 2^21 or 2^20 clocks, dc high for code 11
  // -------------------------------------------------------------
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.cnt = st_ff.cnt + 1'b1;
    unique case (test_frequency_select_i)
      `FREQ_SLOW: nxt_st.level = st_ff.cnt[`FREQ_SLOW_LOG2-1];
      `FREQ_FAST: nxt_st.level = st_ff.cnt[`FREQ_FAST_LOG2-1];
      `FREQ_DC: nxt_st.level = 1'b1;
      // Forbidden code holds the output still
      default: nxt_st.level = st_ff.level;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign test_level_o = st_ff.level;

endmodule : test_pulse_gen

//--- cfg_bank_properties.sv
module cfg_bank_properties
  import cfg_bank_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock, reset and register port
  input wire logic                  sys_clk_i,
  input wire logic                  rst_n_i,
  input wire logic [7:0]            addr_i,
  input wire logic [7:0]            wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [7:0]            rdata_o,
  // Pins and outputs
  input wire logic                  clock_source_select_pin_i,
  input wire logic                  osc_clk_i,
  input wire logic [NUM_CH*3-1:0]   channel_input_select_i,
  input wire logic                  clk_pin_o,
  input wire logic                  clk_pin_oe_o,
  input wire cfg_bank_pkg::ctrl_s   ctrl_o,
  input wire logic [12:0]           modulator_divider_o,
  input wire logic                  test_level_o,
  input wire logic [NUM_CH-1:0]     bias_route_o,
  input wire logic                  irq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [NUM_CH-1:0] route_exp;

  // Expected routing, one channel per select code
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      route_exp[i] = ctrl_o.bias_measure_route &&
                     channel_input_select_i[3*i +: 3] == 3'h2;
    end
  end

  // ---------------------------------------------------------------
  // Write sequences
  // ---------------------------------------------------------------
  sequence s_rate_wr;
    wr_i && addr_i == 8'h01 && wdata_i[2:0] != 3'h7;
  endsequence
  sequence s_bad_rate_wr;
    wr_i && addr_i == 8'h01 && wdata_i[2:0] == 3'h7;
  endsequence
  sequence s_irq_off;
    wr_i && addr_i == 8'h06 && wdata_i == 8'h00 ##1
      !(wr_i && addr_i == 8'h06);
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_DIV_WRITE: assert property (s_rate_wr |-> ##2
    modulator_divider_o == (13'h0040 << $past(wdata_i[2:0], 2)))
    else $error("divider does not follow rate code");
  AST_DIV_HOLD: assert property (s_bad_rate_wr |-> ##2
    $stable(modulator_divider_o))
    else $error("divider moved on reserved rate code");
  AST_DIV_LEGAL: assert property (
    $onehot(modulator_divider_o) && modulator_divider_o >= 13'h0040)
    else $error("divider outside legal set");
  AST_CLK_GATE: assert property (
    clk_pin_o == (osc_clk_i && clk_pin_oe_o))
    else $error("clock pin not gated oscillator");
  AST_OE_SELECT: assert property (
    !clock_source_select_pin_i [*4] |-> !clk_pin_oe_o)
    else $error("clock pin driven with select low");
  AST_ROUTE: assert property (bias_route_o == route_exp)
    else $error("bias routing mismatch");
  AST_TEST_DC: assert property ((ctrl_o.test_internal &&
    ctrl_o.test_frequency_select == 2'h3) [*3] |-> test_level_o)
    else $error("dc test level not high");
  AST_TEST_OFF: assert property (
    !ctrl_o.test_internal [*2] |-> !test_level_o)
    else $error("test level with external source");
  AST_IRQ_OFF: assert property (s_irq_off |=> !irq_o)
    else $error("interrupt high with all enables clear");
endmodule : cfg_bank_properties

//--- testbench.sv
`include "cfg_bank_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_bank_pkg::*;

  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        clock_source_select_pin_i = 1'b0;
  logic        bias_open_i = 1'b0;
  logic        osc_clk_i = 1'b0;
  logic [23:0] channel_input_select_i = {{7{3'h1}}, 3'h2};
  logic [7:0]  rdata_o;
  logic        clk_pin_o;
  logic        clk_pin_oe_o;
  ctrl_s       ctrl_o;
  logic [12:0] modulator_divider_o;
  logic        test_level_o;
  logic [7:0]  bias_route_o;
  logic        irq_o;
  int          n_errors = 0;
  int          n_compared = 0;
  logic [7:0]  tsig [4] = '{8'hc5, 8'hd0, 8'hc4, 8'hd3};

  adc_config_register_bank i_adc_config_register_bank (
    .sys_clk_i                 (sys_clk_i),
    .rst_n_i                   (rst_n_i),
    .addr_i                    (addr_i),
    .wdata_i                   (wdata_i),
    .wr_i                      (wr_i),
    .rd_i                      (rd_i),
    .rdata_o                   (rdata_o),
    .clock_source_select_pin_i (clock_source_select_pin_i),
    .bias_open_i               (bias_open_i),
    .osc_clk_i                 (osc_clk_i),
    .channel_input_select_i    (channel_input_select_i),
    .clk_pin_o                 (clk_pin_o),
    .clk_pin_oe_o              (clk_pin_oe_o),
    .ctrl_o                    (ctrl_o),
    .modulator_divider_o       (modulator_divider_o),
    .test_level_o              (test_level_o),
    .bias_route_o              (bias_route_o),
    .irq_o                     (irq_o)
  );

  // Clock and a slower stand-in for the oscillator
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) osc_clk_i <= ~osc_clk_i;

  task automatic check(input string name, input logic [12:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata", rdata_o, exp);
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_n

  // Write then read back with no gap, so a one-cycle fault shows
  task automatic wr_rd(input logic [7:0] a, d, exp);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata", rdata_o, exp);
  endtask : wr_rd

  // All five reference and bias controls against one level
  task automatic check_bias(input logic v);
    check("ref_buf", ctrl_o.ref_buffer_enable, v);
    check("meas", ctrl_o.bias_measure_route, v);
    check("bias_ref", ctrl_o.bias_reference_internal, v);
    check("bias_buf", ctrl_o.bias_buffer_enable, v);
    check("sense", ctrl_o.bias_sense_enable, v);
  endtask : check_bias

  task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Watchdog, a hang counts as a failure
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`ADR_RATE_CLK, 8'h96);
    rd(`ADR_TEST_SIG, 8'hc0);
    rd(`ADR_REF_BIAS, 8'h60);
    rd(`ADR_IRQ_STATUS, 8'h00);
    rd(8'h3f, 8'h00);
    check("divider", modulator_divider_o, 13'h1000);
    for (int c = 0; c < 7; c++) begin
      wr(`ADR_RATE_CLK, 8'h90 | 8'(c));
      wait_n(1);
      check("divider", modulator_divider_o,
            13'h0040 << c);
    end
    // Reserved rate code: divider holds and the status flags it
    wr(`ADR_RATE_CLK, 8'h97);
    wait_n(2);
    check("divider", modulator_divider_o, 13'h1000);
    rd(`ADR_IRQ_STATUS, 8'h04);
    wr(`ADR_IRQ_CLEAR, 8'h04);
    rd(`ADR_IRQ_STATUS, 8'h00);
    // Chain mode follows its bit alone; clock output needs both pin and bit
    wr(`ADR_RATE_CLK, 8'hf6);
    check("chain", ctrl_o.chain_readback, 1'b1);
    check("oe", clk_pin_oe_o, 1'b0);
    @(posedge sys_clk_i) clock_source_select_pin_i <= 1'b1;
    wait_n(4);
    check("oe", clk_pin_oe_o, 1'b1);
    // Both oscillator phases, so a stuck pin cannot pass
    check("clk_pin", clk_pin_o, osc_clk_i);
    wait_n(1);
    check("clk_pin", clk_pin_o, osc_clk_i);
    wr(`ADR_RATE_CLK, 8'h96);
    wait_n(1);
    check("oe", clk_pin_oe_o, 1'b0);
    check("chain", ctrl_o.chain_readback, 1'b0);
    // Test signal fields; the dc code is left last
    foreach (tsig[i]) begin
      wr(`ADR_TEST_SIG, tsig[i]);
      check("internal", ctrl_o.test_internal, tsig[i][4]);
      check("amp", ctrl_o.test_amp_double, tsig[i][2]);
      check("freq", ctrl_o.test_frequency_select,
            tsig[i][1:0]);
      rd(`ADR_TEST_SIG, tsig[i]);
    end
    wait_n(3);
    check("test_level", test_level_o, 1'b1);
    // Reference and bias controls; the flag bit is not writable
    wr_rd(`ADR_REF_BIAS, 8'hff, 8'hfe);
    check_bias(1'b1);
    check("route", bias_route_o, 8'h01);
    // A second channel picks the bias input code
    @(posedge sys_clk_i) channel_input_select_i[17:15] <= 3'h2;
    wait_n(1);
    check("route", bias_route_o, 8'h21);
    @(posedge sys_clk_i) bias_open_i <= 1'b1;
    wait_n(5);
    rd(`ADR_REF_BIAS, 8'hff);
    rd(`ADR_IRQ_STATUS, 8'h01);
    wr(`ADR_IRQ_ENABLE, 8'h01);
    wait_n(1);
    check("irq", irq_o, 1'b1);
    wr_rd(`ADR_REF_BIAS, 8'hfe, 8'hff);
    wr(`ADR_IRQ_CLEAR, 8'h01);
    wait_n(1);
    check("irq", irq_o, 1'b0);
    @(posedge sys_clk_i) bias_open_i <= 1'b0;
    wait_n(5);
    rd(`ADR_REF_BIAS, 8'hfe);
    rd(`ADR_IRQ_STATUS, 8'h02);
    check("irq", irq_o, 1'b0);
    wr(`ADR_REF_BIAS, 8'h60);
    check_bias(1'b0);
    check("route", bias_route_o, 8'h00);
    wr(`ADR_IRQ_ENABLE, 8'h00);
    wait_n(2);
    print_verdict();
  end
endmodule : testbench

bind adc_config_register_bank cfg_bank_properties #(.NUM_CH(NUM_CH)) i_props (
  .sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .clock_source_select_pin_i, .osc_clk_i, .channel_input_select_i,
  .clk_pin_o, .clk_pin_oe_o, .ctrl_o, .modulator_divider_o,
  .test_level_o, .bias_route_o, .irq_o
);
